/* logic/adgs_pkg.sv */
// Constants, offsets and types for the converter group trigger block
`default_nettype none
package adgs_pkg;
	// Group indices
	localparam int NUM_GROUPS = 3;
	localparam int NUM_SRC = 8;
	localparam logic [1:0] GRP_EVENT = 2'h0;
	localparam logic [1:0] GRP_ONE = 2'h1;
	localparam logic [1:0] GRP_TWO = 2'h2;
	// Global register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	// Per-group offsets inside a 32-byte window at 0x20, 0x40, 0x60
	localparam logic [4:0] GOFS_CFG = 5'h00;
	localparam logic [4:0] GOFS_CHSEL = 5'h04;
	localparam logic [4:0] GOFS_THR = 5'h08;
	localparam logic [4:0] GOFS_MAG = 5'h0C;
	localparam logic [4:0] GOFS_RES = 5'h10;
	localparam logic [4:0] GOFS_CNT = 5'h14;
	// Control register fields
	localparam int CTRL_APD_BIT = 0;
	localparam int CTRL_FMT_LSB = 1;
	localparam int CTRL_DIR_BIT = 3;
	localparam int CTRL_OUT_BIT = 4;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_PIN_BIT = 2;
	localparam int STAT_IRQ_LSB = 4;
	localparam int STAT_MAG_LSB = 8;
	// Group configuration fields
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_HWEN_BIT = 3;
	localparam int CFG_CONT_BIT = 4;
	localparam int CFG_DMA_BIT = 5;
	localparam int CFG_START_BIT = 6;
	// Magnitude register fields
	localparam int MAG_CH_LSB = 0;
	localparam int MAG_VAL_LSB = 16;
	// Result word fields
	localparam int RES_CH_LSB = 16;
	// Read format codes
	localparam logic [1:0] FMT_12 = 2'h0;
	localparam logic [1:0] FMT_10 = 2'h1;
	localparam logic [1:0] FMT_8 = 2'h2;
	// Pin-mux control bits of register 30
	localparam int PMUX_DEF_BIT = 0;
	localparam int PMUX_ALT_BIT = 1;
	// Reset values
	localparam logic [1:0] RST_FMT = 2'h0;
	localparam logic [2:0] RST_SEL = 3'h0;
	localparam logic [31:0] RST_RDATA = 32'h0;
	// Engine states
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} adgs_state_e;
endpackage : adgs_pkg
`default_nettype wire

/* logic/adgs_trig.sv */
// Trigger source mux, synchroniser and edge detector for one group
`timescale 1ns/1ns
`default_nettype none
module adgs_trig import adgs_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Selection
	input wire logic [2:0] sel_i,
	input wire logic alt_i,
	// Sources
	input wire logic [NUM_SRC-1:0] src_def_i,
	input wire logic [NUM_SRC-1:0] src_alt_i,
	// Edge pulse
	output logic trig_o
);
	logic sel_src;
	logic sync1, sync2, sync3;
	logic next_sync1, next_sync2, next_sync3;

	always_comb begin
		sel_src = alt_i ? src_alt_i[sel_i] : src_def_i[sel_i];
		next_sync1 = sel_src;
		next_sync2 = sync1;
		next_sync3 = sync2;
		trig_o = sync2 & ~sync3;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	edge_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		trig_o |=> !trig_o) else $error("trigger pulse longer than one cycle");
endmodule : adgs_trig
`default_nettype wire

/* logic/adgs_top.sv */
// Converter group control: triggers, sequencing, result regions, flags
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Three groups, each hardware triggerable from one of eight sources.
// - Default map: event pin, timer 8/10/12/14, compare 0, port B 0/1.
// - Alternate map: event pin, compare 0, chosen channels of both timer units.
// - Mux bit 0 set selects default hookup for second converter.
// - Mux bit 0 clear and bit 1 set selects alternate hookup.
// - Pin triggers come from pad input buffer output.
// - Timer triggers for alternate map come from timer module boundary.
// - Compare 0 trigger comes straight from interrupt timer output.
// - Separate result region for event, group 1 and group 2.
// - Any channel may be assigned to any group.
// - Each region serviced by interrupt or DMA request.
// - Group interrupt when stored result count reaches threshold.
// - Magnitude threshold interrupt on one selected channel per group.
// - Result reads formatted as 8, 10 or 12 bits.
// - Single mode stops after one pass; continuous repeats.
// - Auto power-down keeps core off while no conversion runs.
// - Event pin usable as general-purpose input/output.
module adgs_top import adgs_pkg::*; #(
	parameter int CH_NUM = 16,
	parameter int RES_DEPTH = 16,
	parameter int SECOND_CONV = 1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Trigger sources
	input wire logic [31:0] timer_channel_output_i,
	input wire logic [31:0] first_timer_unit_i,
	input wire logic [19:0] second_timer_unit_i,
	input wire logic interrupt_timer_cmp0_i,
	input wire logic [1:0] port_b_pin_i,
	input wire logic [1:0] pinmux_ctrl30_i,
	// Event pin
	input wire logic converter_event_pin_i,
	output logic converter_event_pin_o,
	output logic converter_event_pin_oe_o,
	// Converter core
	output logic conv_start_o,
	output logic [$clog2(CH_NUM)-1:0] conv_chan_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	output logic core_power_down_o,
	// Servicing
	output logic [NUM_GROUPS-1:0] grp_irq_o,
	output logic [NUM_GROUPS-1:0] grp_dma_req_o,
	output logic [NUM_GROUPS-1:0] mag_irq_o
);
	localparam int CHW = $clog2(CH_NUM);
	localparam int AW = $clog2(RES_DEPTH);
	localparam logic [CHW:0] CH_NONE = (CHW+1)'(CH_NUM);
	localparam logic [AW:0] DEPTH_FULL = (AW+1)'(RES_DEPTH);

	logic apd_en, next_apd_en;
	logic [1:0] rd_fmt, next_rd_fmt;
	logic gpio_dir, next_gpio_dir, gpio_out, next_gpio_out;
	logic [2:0] tsel [NUM_GROUPS];
	logic [2:0] next_tsel [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] hw_en, next_hw_en, cont, next_cont, dma_en, next_dma_en;
	logic [CH_NUM-1:0] chsel [NUM_GROUPS];
	logic [CH_NUM-1:0] next_chsel [NUM_GROUPS];
	logic [AW:0] thr [NUM_GROUPS];
	logic [AW:0] next_thr [NUM_GROUPS];
	logic [CHW-1:0] mag_ch [NUM_GROUPS];
	logic [CHW-1:0] next_mag_ch [NUM_GROUPS];
	logic [11:0] mag_val [NUM_GROUPS];
	logic [11:0] next_mag_val [NUM_GROUPS];
	logic [AW-1:0] wr_ptr [NUM_GROUPS];
	logic [AW-1:0] next_wr_ptr [NUM_GROUPS];
	logic [AW-1:0] rd_ptr [NUM_GROUPS];
	logic [AW-1:0] next_rd_ptr [NUM_GROUPS];
	logic [AW:0] cnt [NUM_GROUPS];
	logic [AW:0] next_cnt [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] irq_flg, next_irq_flg, mag_flg, next_mag_flg, pend, next_pend;
	adgs_state_e state, next_state;
	logic [1:0] cur_g, next_cur_g;
	logic [CHW-1:0] cur_ch, next_cur_ch;
	logic pd, next_pd;
	logic [31:0] rdata, next_rdata;
	logic [CHW+11:0] res_mem [NUM_GROUPS][RES_DEPTH];

	logic [NUM_GROUPS-1:0] trig;
	logic use_alt;
	logic [NUM_SRC-1:0] src_def, src_alt;
	logic store, grp_hit, rd_res;
	logic [1:0] acc_g;
	logic [CHW:0] next_in_grp;
	logic [CHW+11:0] res_word;

	function automatic logic [CHW:0] find_ch(input logic [CH_NUM-1:0] m, input logic [CHW:0] from);
		logic [CHW:0] r;
		r = CH_NONE;
		for (int i = CH_NUM - 1; i >= 0; i--) begin
			if (m[i] && (i >= int'(from))) begin
				r = (CHW+1)'(i);
			end
		end
		return r;
	endfunction : find_ch

	function automatic logic [11:0] fmt_data(input logic [11:0] d, input logic [1:0] f);
		case (f)
			FMT_10: return {2'h0, d[11:2]};
			FMT_8: return {4'h0, d[11:4]};
			default: return d;
		endcase
	endfunction : fmt_data

	// Trigger hookups
	always_comb begin
		src_def = {port_b_pin_i[1], port_b_pin_i[0], timer_channel_output_i[14],
			timer_channel_output_i[12], interrupt_timer_cmp0_i, timer_channel_output_i[10],
			timer_channel_output_i[8], converter_event_pin_i};
		src_alt = {second_timer_unit_i[13], first_timer_unit_i[11], first_timer_unit_i[19],
			first_timer_unit_i[17], interrupt_timer_cmp0_i, first_timer_unit_i[27],
			second_timer_unit_i[5], converter_event_pin_i};
		use_alt = (SECOND_CONV != 0) && !pinmux_ctrl30_i[PMUX_DEF_BIT]
			&& pinmux_ctrl30_i[PMUX_ALT_BIT];
	end

	for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_trig
		adgs_trig u_trig (
			.ref_clk_i(ref_clk_i),
			.rst_b_i(rst_b_i),
			.sel_i(tsel[g]),
			.alt_i(use_alt),
			.src_def_i(src_def),
			.src_alt_i(src_alt),
			.trig_o(trig[g])
		);
	end

	// Decode and result path
	always_comb begin
		acc_g = reg_addr_i[6:5] - 2'h1;
		grp_hit = !reg_addr_i[7] && (reg_addr_i[6:5] != 2'h0);
		rd_res = reg_rd_i && grp_hit && (reg_addr_i[4:0] == GOFS_RES) && (cnt[acc_g] != '0);
		res_word = res_mem[acc_g][rd_ptr[acc_g]];
		store = (state == ST_WAIT) && conv_done_i;
		next_in_grp = find_ch(chsel[cur_g], (CHW+1)'(cur_ch) + (CHW+1)'(1));
	end

	// Register file, flags, sequencer
	always_comb begin
		next_apd_en = apd_en;
		next_rd_fmt = rd_fmt;
		next_gpio_dir = gpio_dir;
		next_gpio_out = gpio_out;
		next_tsel = tsel;
		next_hw_en = hw_en;
		next_cont = cont;
		next_dma_en = dma_en;
		next_chsel = chsel;
		next_thr = thr;
		next_mag_ch = mag_ch;
		next_mag_val = mag_val;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_cnt = cnt;
		next_irq_flg = irq_flg;
		next_mag_flg = mag_flg;
		next_pend = pend;
		next_state = state;
		next_cur_g = cur_g;
		next_cur_ch = cur_ch;
		next_rdata = RST_RDATA;
		// Software writes
		if (reg_wr_i && (reg_addr_i == OFS_CTRL)) begin
			next_apd_en = reg_wdata_i[CTRL_APD_BIT];
			next_rd_fmt = reg_wdata_i[CTRL_FMT_LSB +: 2];
			next_gpio_dir = reg_wdata_i[CTRL_DIR_BIT];
			next_gpio_out = reg_wdata_i[CTRL_OUT_BIT];
		end
		if (reg_wr_i && (reg_addr_i == OFS_STAT)) begin
			next_irq_flg = irq_flg & ~reg_wdata_i[STAT_IRQ_LSB +: NUM_GROUPS];
			next_mag_flg = mag_flg & ~reg_wdata_i[STAT_MAG_LSB +: NUM_GROUPS];
		end
		if (reg_wr_i && grp_hit) begin
			case (reg_addr_i[4:0])
				GOFS_CFG: begin
					next_tsel[acc_g] = reg_wdata_i[CFG_SEL_LSB +: 3];
					next_hw_en[acc_g] = reg_wdata_i[CFG_HWEN_BIT];
					next_cont[acc_g] = reg_wdata_i[CFG_CONT_BIT];
					next_dma_en[acc_g] = reg_wdata_i[CFG_DMA_BIT];
				end
				GOFS_CHSEL: next_chsel[acc_g] = reg_wdata_i[CH_NUM-1:0];
				GOFS_THR: next_thr[acc_g] = reg_wdata_i[AW:0];
				GOFS_MAG: begin
					next_mag_ch[acc_g] = reg_wdata_i[MAG_CH_LSB +: CHW];
					next_mag_val[acc_g] = reg_wdata_i[MAG_VAL_LSB +: 12];
				end
				default: ;
			endcase
		end
		// Reads, result pop
		if (reg_rd_i) begin
			if (reg_addr_i == OFS_CTRL) begin
				next_rdata = {27'h0, gpio_out, gpio_dir, rd_fmt, apd_en};
			end else if (reg_addr_i == OFS_STAT) begin
				next_rdata[STAT_BUSY_BIT] = (state != ST_IDLE);
				next_rdata[STAT_PD_BIT] = pd;
				next_rdata[STAT_PIN_BIT] = converter_event_pin_i;
				next_rdata[STAT_IRQ_LSB +: NUM_GROUPS] = irq_flg;
				next_rdata[STAT_MAG_LSB +: NUM_GROUPS] = mag_flg;
			end else if (grp_hit) begin
				case (reg_addr_i[4:0])
					GOFS_CFG: next_rdata = {26'h0, dma_en[acc_g], cont[acc_g], hw_en[acc_g],
						tsel[acc_g]};
					GOFS_CHSEL: next_rdata[CH_NUM-1:0] = chsel[acc_g];
					GOFS_THR: next_rdata[AW:0] = thr[acc_g];
					GOFS_MAG: begin
						next_rdata[MAG_CH_LSB +: CHW] = mag_ch[acc_g];
						next_rdata[MAG_VAL_LSB +: 12] = mag_val[acc_g];
					end
					GOFS_RES: if (rd_res) begin
						next_rdata[RES_CH_LSB +: CHW] = res_word[CHW+11:12];
						next_rdata[11:0] = fmt_data(res_word[11:0], rd_fmt);
						next_rd_ptr[acc_g] = rd_ptr[acc_g] + AW'(1);
						next_cnt[acc_g] = cnt[acc_g] - (AW+1)'(1);
					end
					GOFS_CNT: next_rdata[AW:0] = cnt[acc_g];
					default: ;
				endcase
			end
		end
		// Result storage into the active group region
		if (store && (cnt[cur_g] != DEPTH_FULL)) begin
			next_wr_ptr[cur_g] = wr_ptr[cur_g] + AW'(1);
			next_cnt[cur_g] = next_cnt[cur_g] + (AW+1)'(1);
			if (!dma_en[cur_g] && (thr[cur_g] != '0) && (next_cnt[cur_g] == thr[cur_g])) begin
				next_irq_flg[cur_g] = 1'b1;
			end
		end
		if (store && (cur_ch == mag_ch[cur_g]) && (conv_data_i > mag_val[cur_g])) begin
			next_mag_flg[cur_g] = 1'b1;
		end
		// Sequencer
		case (state)
			ST_IDLE: begin
				for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
					if (pend[g]) begin
						next_cur_g = 2'(g);
					end
				end
				if (pend != '0) begin
					next_pend[next_cur_g] = 1'b0;
					if (find_ch(chsel[next_cur_g], '0) != CH_NONE) begin
						next_cur_ch = CHW'(find_ch(chsel[next_cur_g], '0));
						next_state = ST_START;
					end
				end
			end
			ST_START: next_state = ST_WAIT;
			ST_WAIT: if (conv_done_i) begin
				if (next_in_grp != CH_NONE) begin
					next_cur_ch = CHW'(next_in_grp);
					next_state = ST_START;
				end else if (cont[cur_g] && (find_ch(chsel[cur_g], '0) != CH_NONE)) begin
					next_cur_ch = CHW'(find_ch(chsel[cur_g], '0));
					next_state = ST_START;
				end else begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Trigger and software start set pending after any clear
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if ((trig[g] && hw_en[g]) || (reg_wr_i && grp_hit && (acc_g == 2'(g))
				&& (reg_addr_i[4:0] == GOFS_CFG) && reg_wdata_i[CFG_START_BIT])) begin
				next_pend[g] = 1'b1;
			end
		end
		next_pd = apd_en && (next_state == ST_IDLE) && (next_pend == '0);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			apd_en <= 1'b0;
			rd_fmt <= RST_FMT;
			gpio_dir <= 1'b0;
			gpio_out <= 1'b0;
			tsel <= '{default: RST_SEL};
			hw_en <= '0;
			cont <= '0;
			dma_en <= '0;
			chsel <= '{default: '0};
			thr <= '{default: '0};
			mag_ch <= '{default: '0};
			mag_val <= '{default: '0};
			wr_ptr <= '{default: '0};
			rd_ptr <= '{default: '0};
			cnt <= '{default: '0};
			irq_flg <= '0;
			mag_flg <= '0;
			pend <= '0;
			state <= ST_IDLE;
			cur_g <= GRP_EVENT;
			cur_ch <= '0;
			pd <= 1'b0;
			rdata <= RST_RDATA;
		end else begin
			apd_en <= next_apd_en;
			rd_fmt <= next_rd_fmt;
			gpio_dir <= next_gpio_dir;
			gpio_out <= next_gpio_out;
			tsel <= next_tsel;
			hw_en <= next_hw_en;
			cont <= next_cont;
			dma_en <= next_dma_en;
			chsel <= next_chsel;
			thr <= next_thr;
			mag_ch <= next_mag_ch;
			mag_val <= next_mag_val;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			irq_flg <= next_irq_flg;
			mag_flg <= next_mag_flg;
			pend <= next_pend;
			state <= next_state;
			cur_g <= next_cur_g;
			cur_ch <= next_cur_ch;
			pd <= next_pd;
			rdata <= next_rdata;
		end
	end

	// Result regions, one per group
	always_ff @(posedge ref_clk_i) begin
		if (store && (cnt[cur_g] != DEPTH_FULL)) begin
			res_mem[cur_g][wr_ptr[cur_g]] <= {cur_ch, conv_data_i};
		end
	end

	always_comb begin
		reg_rdata_o = rdata;
		conv_start_o = (state == ST_START);
		conv_chan_o = cur_ch;
		core_power_down_o = pd;
		converter_event_pin_o = gpio_out;
		converter_event_pin_oe_o = gpio_dir;
		grp_irq_o = irq_flg;
		mag_irq_o = mag_flg;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			grp_dma_req_o[g] = dma_en[g] && (thr[g] != '0) && (cnt[g] >= thr[g]);
		end
	end

	hw_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(trig[0] && hw_en[0] && (state == ST_IDLE) && (pend == '0) && (chsel[0] != '0)
		&& !(reg_wr_i && grp_hit))
		|-> ##2 (conv_start_o && (cur_g == GRP_EVENT))) else $error("trigger did not start group");
	hookup_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		pinmux_ctrl30_i[PMUX_DEF_BIT] |-> !use_alt) else $error("default hookup not used");
	alt_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!pinmux_ctrl30_i[PMUX_DEF_BIT] && pinmux_ctrl30_i[PMUX_ALT_BIT] && (SECOND_CONV != 0))
		|-> use_alt) else $error("alternate hookup not used");
	single_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(store && !cont[cur_g] && (next_in_grp == CH_NONE)) |=> (state == ST_IDLE))
		else $error("single pass did not stop");
	cont_loop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(store && cont[cur_g] && (chsel[cur_g] != '0)) |=> conv_start_o ##1 !conv_start_o)
		else $error("continuous pass did not repeat");
	thr_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(irq_flg[GRP_ONE]) |-> ((cnt[GRP_ONE] == thr[GRP_ONE]) && $past(store)))
		else $error("group interrupt without threshold");
	dma_no_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		dma_en[GRP_ONE] |=> !$rose(irq_flg[GRP_ONE])) else $error("interrupt raised in dma mode");
	mag_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(store && (cur_g == GRP_EVENT) && (cur_ch == mag_ch[GRP_EVENT])
		&& (conv_data_i > mag_val[GRP_EVENT])) |=> mag_flg[GRP_EVENT])
		else $error("magnitude flag missed");
	fmt_eight_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(rd_res && (rd_fmt == FMT_8)) |=> (reg_rdata_o[11:8] == 4'h0))
		else $error("8-bit read has upper bits");
	pwr_down_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		core_power_down_o |-> (apd_en || $past(apd_en)) && (state == ST_IDLE))
		else $error("core down while converting");
endmodule : adgs_top
`default_nettype wire

/* tb/adgs_core_model.sv */
// Behavioural converter core answering start pulses
`timescale 1ns/1ns
`default_nettype none
module adgs_core_model #(
	parameter int DLY_FAST = 2,
	parameter int DLY_SLOW = 9
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Requests
	input wire logic start_i,
	input wire logic slow_i,
	input wire logic [11:0] sample_i,
	// Answer
	output logic done_o,
	output logic [11:0] data_o
);
	int cnt;
	logic busy;
	// Data toggles outside the done cycle so a stale value never looks valid
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (!rst_b_i) begin
			busy <= 1'b0;
			data_o <= 12'h000;
		end else if (start_i && !busy) begin
			busy <= 1'b1;
			cnt <= slow_i ? DLY_SLOW : DLY_FAST;
		end else if (busy) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				busy <= 1'b0;
				done_o <= 1'b1;
				data_o <= sample_i;
			end
		end
	end
endmodule : adgs_core_model
`default_nettype wire

/* tb/adgs_top_tb_top.sv */
// Self-checking bench for the converter group trigger block
`timescale 1ns/1ns
`default_nettype none
module adgs_top_tb_top import adgs_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] tco = 32'h0;
	logic [31:0] ftu = 32'h0;
	logic [19:0] stu = 20'h0;
	logic cmp0 = 1'b0;
	logic [1:0] pb = 2'h0;
	logic [1:0] pmux = 2'h1;
	logic evp = 1'b0;
	logic slow = 1'b0;
	logic [11:0] sample = 12'h000;
	wire logic [31:0] rdata;
	wire logic evp_o, evp_oe, cstart, cpd, cdone;
	wire logic [3:0] cchan;
	wire logic [11:0] cdata;
	wire logic [2:0] girq, gdma, mirq;
	int seed = 31669;
	int err_total = 0;
	int samples_checked = 0;
	int conv_n = 0;
	logic [31:0] expq[$];

	always #20 ref_clk_i = ~ref_clk_i;

	adgs_top #(.CH_NUM(16), .RES_DEPTH(16), .SECOND_CONV(1)) dut (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .timer_channel_output_i(tco),
		.first_timer_unit_i(ftu), .second_timer_unit_i(stu), .interrupt_timer_cmp0_i(cmp0),
		.port_b_pin_i(pb), .pinmux_ctrl30_i(pmux), .converter_event_pin_i(evp),
		.converter_event_pin_o(evp_o), .converter_event_pin_oe_o(evp_oe),
		.conv_start_o(cstart), .conv_chan_o(cchan), .conv_done_i(cdone),
		.conv_data_i(cdata), .core_power_down_o(cpd), .grp_irq_o(girq),
		.grp_dma_req_o(gdma), .mag_irq_o(mirq));

	adgs_core_model core (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(cstart),
		.slow_i(slow), .sample_i(sample), .done_o(cdone), .data_o(cdata));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task stop_test;
		$display("checks=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	task settle(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : settle

	task rst_seq;
		rst_b_i <= 1'b0;
		settle(16);
		rst_b_i <= 1'b1;
	endtask : rst_seq

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		expq.push_back(e);
		@(posedge ref_clk_i);
		rd <= 1'b0;
	endtask : rd_chk

	task wait_conv(input int n);
		int i;
		int k;
		for (k = 0; k < n; k++) begin
			i = 0;
			do begin
				@(negedge ref_clk_i);
				i++;
			end while (cdone !== 1'b1 && i < 200);
			if (i >= 200) begin
				err_total++;
				stop_test();
			end
		end
		settle(3);
	endtask : wait_conv

	function automatic logic [7:0] gb(input int g, input logic [4:0] ofs);
		return 8'h20 + 8'(g * 32) + {3'h0, ofs};
	endfunction : gb

	function automatic logic [31:0] res(input logic [3:0] ch, input logic [1:0] f,
		input logic [11:0] d);
		logic [11:0] v;
		v = (f == FMT_10) ? (d >> 2) : ((f == FMT_8) ? (d >> 4) : d);
		return {12'h000, ch, 4'h0, v};
	endfunction : res

	task src(input bit alt, input int c, input logic v);
		case (c)
			0: evp <= v;
			3: cmp0 <= v;
			1: if (alt) stu[5] <= v; else tco[8] <= v;
			2: if (alt) ftu[27] <= v; else tco[10] <= v;
			4: if (alt) ftu[17] <= v; else tco[12] <= v;
			5: if (alt) ftu[19] <= v; else tco[14] <= v;
			6: if (alt) ftu[11] <= v; else pb[0] <= v;
			default: if (alt) stu[13] <= v; else pb[1] <= v;
		endcase
	endtask : src

	task pulse(input bit alt, input int c);
		@(posedge ref_clk_i);
		src(alt, c, 1'b1);
		settle(6);
		src(alt, c, 1'b0);
		settle(30);
	endtask : pulse

	// Read data checked in the cycle after each read strobe
	always @(posedge ref_clk_i) rd_d <= rd;
	always @(negedge ref_clk_i) begin
		if (rd_d) check(rdata, (expq.size() > 0) ? expq.pop_front() : 32'hDEADBEEF);
	end
	always @(posedge ref_clk_i) begin
		if (cstart === 1'b1) conv_n++;
	end

	initial begin
		settle(100000);
		err_total++;
		stop_test();
	end

	initial begin
		logic [3:0] c1;
		logic [1:0] f;
		logic [1:0] pm;
		bit alt;
		int e1;
		int n;
		rst_seq();
		rd_chk(OFS_CTRL, 32'h0);
		rd_chk(OFS_STAT, 32'h0);
		for (int g = 0; g < NUM_GROUPS; g++) rd_chk(gb(g, GOFS_CNT), 32'h0);
		wr_reg(8'hFC, 32'hFFFFFFFF);
		rd_chk(8'hFC, 32'h0);
		$display("test reset done");
		// Software passes in each group and read format
		for (int g = 0; g < NUM_GROUPS; g++) begin
			f = 2'(g);
			c1 = 4'($random(seed) & 7);
			sample = 12'($random(seed));
			wr_reg(OFS_CTRL, {29'h0, f, 1'b0});
			wr_reg(gb(g, GOFS_CHSEL), 32'(1 << c1) | 32'(1 << (c1 + 8)));
			wr_reg(gb(g, GOFS_CFG), 32'h40);
			wait_conv(2);
			settle(20);
			rd_chk(gb(g, GOFS_CNT), 32'h2);
			rd_chk(gb(g, GOFS_RES), res(c1, f, sample));
			rd_chk(gb(g, GOFS_RES), res(c1 + 4'h8, f, sample));
			rd_chk(gb(g, GOFS_CNT), 32'h0);
		end
		$display("test format done");
		// Auto power-down and pin as general output; pin trigger left disabled
		wr_reg(OFS_STAT, 32'h770);
		wr_reg(OFS_CTRL, 32'h19);
		evp <= 1'b1;
		settle(4);
		check(cpd, 1'b1);
		check({evp_oe, evp_o}, 2'h3);
		rd_chk(OFS_STAT, 32'h6);
		slow <= 1'b1;
		wr_reg(gb(0, GOFS_CHSEL), 32'h1);
		wr_reg(gb(0, GOFS_CFG), 32'h40);
		settle(5);
		check(cpd, 1'b0);
		wait_conv(1);
		check(cpd, 1'b1);
		slow <= 1'b0;
		evp <= 1'b0;
		wr_reg(OFS_CTRL, 32'h0);
		rd_chk(gb(0, GOFS_RES), res(4'h0, FMT_12, sample));
		$display("test power done");
		// Count threshold, magnitude flag, then DMA servicing
		sample = 12'($random(seed)) | 12'h001;
		wr_reg(OFS_STAT, 32'h770);
		wr_reg(gb(1, GOFS_THR), 32'h2);
		wr_reg(gb(1, GOFS_MAG), {4'h0, sample - 12'h001, 12'h000, 4'h3});
		wr_reg(gb(1, GOFS_CHSEL), 32'h0018);
		wr_reg(gb(1, GOFS_CFG), 32'h40);
		wait_conv(2);
		check({mirq, girq}, 6'h12);
		check(cchan, 4'h4);
		rd_chk(OFS_STAT, 32'h220);
		wr_reg(OFS_STAT, 32'h770);
		rd_chk(OFS_STAT, 32'h0);
		rd_chk(gb(1, GOFS_RES), res(4'h3, FMT_12, sample));
		rd_chk(gb(1, GOFS_RES), res(4'h4, FMT_12, sample));
		wr_reg(gb(1, GOFS_CFG), 32'h60);
		wait_conv(2);
		check({gdma, girq}, 6'h10);
		rd_chk(gb(1, GOFS_RES), res(4'h3, FMT_12, sample));
		rd_chk(gb(1, GOFS_RES), res(4'h4, FMT_12, sample));
		settle(1);
		check(gdma, 3'h0);
		$display("test service done");
		// Continuous mode repeats until switched off
		wr_reg(gb(2, GOFS_CHSEL), 32'h1);
		wr_reg(gb(2, GOFS_CFG), 32'h50);
		wait_conv(3);
		wr_reg(gb(2, GOFS_CFG), 32'h0);
		settle(20);
		n = conv_n;
		settle(40);
		check(32'(conv_n - n), 32'h0);
		$display("test continuous done");
		// Every code under each hookup setting
		for (int m = 0; m < 4; m++) begin
			pm = (m == 0) ? 2'h1 : ((m == 1) ? 2'h3 : ((m == 2) ? 2'h0 : 2'h2));
			alt = (pm == 2'h2);
			for (int c = 0; c < NUM_SRC; c++) begin
				pmux <= pm;
				sample = 12'($random(seed));
				rst_seq();
				wr_reg(gb(c % 3, GOFS_CHSEL), 32'(1 << c));
				wr_reg(gb(c % 3, GOFS_CFG), 32'(c | 8));
				pulse(1'b0, c);
				e1 = (alt && c != 0 && c != 3) ? 0 : 1;
				rd_chk(gb(c % 3, GOFS_CNT), 32'(e1));
				pulse(1'b1, c);
				rd_chk(gb(c % 3, GOFS_CNT), 32'(e1 + ((!alt && c != 0 && c != 3) ? 0 : 1)));
			end
		end
		settle(4);
		$display("test hookup done");
		stop_test();
	end
endmodule : adgs_top_tb_top
`default_nettype wire
